// *** tb/reply_gen_command_decode_test.sv ***
// Testbench: both ends joined over the link, commands and return RAM
`timescale 1ns/100ps
module reply_gen_command_decode_test;
    import rgcd_pkg::*;
    logic        core_clk_in, sys_rst_in, tbit;
    logic        cmd_req, blk_req, fetch_req, rb_req;
    logic [7:0]  cmd;
    logic [15:0] blk_word, fetched, rd_data;
    logic [1:0]  tsel;
    logic        busy, fetched_v, rd_v, diag, pss, rbs, pac, mde;
    logic [3:0]  pulse;
    rgcd_mode_t  mode;
    int          fails, cmp_count;
    logic [7:0]  cmds [11] = '{8'h0f, 8'h0f, 8'h00, 8'h2f, 8'h4b, 8'h6c,
                               8'h8f, 8'hbf, 8'hbf, 8'ha0, 8'hef};
    // Readback order: held fields, train of ones, fields, train inputs
    logic [15:0] rb_words [4] = '{16'h0f0f, 16'hffff, 16'h0f0f, 16'h3c3c};

    rgcd_if link ();
    rgcd_device i_rgcd_device (.core_clk_in(core_clk_in),
        .sys_rst_in(sys_rst_in), .link(link.device),
        .return_ram_count_enable_in(1'b1), .return_ram_output_enable_in(1'b1),
        .gen_fields_in(16'h0f0f), .gen_train_in(16'h3c3c),
        .gen_train_bit_in(tbit), .gen_transmit_in(tbit),
        .ctrl_pulse_out(pulse), .mode_out(mode), .if_diag_sel_out(diag),
        .ps_select_out(pss), .readback_source_select_out(rbs),
        .program_addr_ctrl_out(pac), .micro_drive_enable_out(mde),
        .gen_read_data_out(rd_data), .gen_read_valid_out(rd_v));
    rgcd_host i_rgcd_host (.core_clk_in(core_clk_in),
        .sys_rst_in(sys_rst_in), .link(link.host), .cmd_req_in(cmd_req),
        .cmd_in(cmd), .block_req_in(blk_req), .block_word_in(blk_word),
        .fetch_req_in(fetch_req), .readback_req_in(rb_req),
        .target_select_in(tsel), .busy_out(busy),
        .fetched_word_out(fetched), .fetched_valid_out(fetched_v));
    rgcd_link_sva i_rgcd_link_sva (.core_clk_in(core_clk_in),
        .sys_rst_in(sys_rst_in), .command(link.command),
        .command_strobe(link.command_strobe),
        .return_ram_load_command(link.return_ram_load_command),
        .host_data_request(link.host_data_request),
        .host_return_valid(link.host_return_valid),
        .ram_read_mode(link.ram_read_mode), .status_bits(link.status_bits));

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic tick();
        @(negedge core_clk_in);
        tbit = ~tbit;
    endtask : tick

    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic results();
        $display("checks %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : results

    function automatic logic flag(input int sel);
        case (sel)
            0: return busy;
            1: return link.ram_read_mode;
            default: return fetched_v;
        endcase
    endfunction : flag

    // Bounded poll; a hang ends the run with a failure
    task automatic wait_for(input int sel, input logic lvl);
        int k;
        k = 0;
        while (flag(sel) !== lvl && k < 60) begin
            tick();
            k++;
        end
        if (k == 60) begin
            fails++;
            $display("mismatch wait %0d expected %b seen %b", sel, lvl,
                     flag(sel));
            results();
        end
    endtask : wait_for

    task automatic send_cmd(input logic [7:0] c);
        int   n [4];
        logic bm;
        n = '{0, 0, 0, 0};
        bm = (c[7:5] == OP_BUF);
        wait_for(0, 1'b0);
        cmd = c;
        cmd_req = 1'b1;
        tick();
        cmd_req = 1'b0;
        for (int k = 0; k < 14; k++) begin
            tick();
            for (int b = 0; b < 4; b++) n[b] += int'(pulse[b] === 1'b1);
        end
        wait_for(0, 1'b0);
        check("reset pulses", 16'(n[0]), 16'(c[0]));
        check("inc reply pulses", 16'(n[1]), 16'(c[1]));
        check("inc addr pulses", 16'(n[2]), 16'(c[2] & bm));
        check("dec reply pulses", 16'(n[3]), 16'(c[3] & bm));
        check("mode", 16'(mode), 16'(exp_mode(c[7:5])));
        check("diag select", 16'(diag), 16'(bm));
        check("ps select", 16'(pss), 16'(bm & c[4]));
        check("source select", 16'(rbs), 16'(bm & c[5]));
        check("program addr", 16'(pac), 16'(bm));
        check("micro drive", 16'(mde), 16'(!bm));
        check("status", 16'(link.status_bits), 16'(c[7:2]));
    endtask : send_cmd

    function automatic rgcd_mode_t exp_mode(input logic [2:0] op);
        case (op)
            3'h0: return RGCD_MODE_NORMAL;
            3'h1: return RGCD_MODE_RF;
            3'h2: return RGCD_MODE_TGT;
            3'h3: return RGCD_MODE_MICRO;
            3'h5: return RGCD_MODE_BUF;
            default: return RGCD_MODE_ILLEGAL;
        endcase
    endfunction : exp_mode

    // ----------------------------------------------------------------
    // Stimulus
    // ----------------------------------------------------------------
    initial begin
        core_clk_in = 1'b0;
        forever #50 core_clk_in = ~core_clk_in;
    end

    initial begin
        int n;
        {cmd_req, blk_req, fetch_req, rb_req, tbit} = 5'h00;
        {cmd, blk_word, tsel} = 26'h0;
        fails = 0;
        cmp_count = 0;
        sys_rst_in = 1'b1;
        repeat (4) tick();
        sys_rst_in = 1'b0;
        check("reset rw mode", 16'(link.ram_read_mode), 16'h0);
        check("reset drive", 16'(mde), 16'h1);
        foreach (cmds[i]) send_cmd(cmds[i]);
        // Return RAM round trip in both modes that use it
        for (int op = 3; op >= 2; op--) begin
            send_cmd({3'(op), 5'h00});
            // Host takes the first word one cycle after the request
            blk_req = 1'b1;
            tick();
            blk_req = 1'b0;
            for (int k = 0; k < 4; k++) begin
                blk_word = 16'(16'ha5c3 * (k + 1) + op);
                tick();
            end
            wait_for(1, 1'b1);
            // One fetch request moves the whole four-word block
            fetch_req = 1'b1;
            tick();
            fetch_req = 1'b0;
            for (int k = 0; k < 4; k++) begin
                wait_for(2, 1'b1);
                check("return word", fetched,
                      16'(16'ha5c3 * (k + 1) + op));
                tick();
            end
            wait_for(1, 1'b0);
        end
        // Readback at every target select value; the words do not depend on it
        for (int t = 0; t < 4; t++) begin
            n = 0;
            tsel = 2'(t);
            rb_req = 1'b1;
            repeat (12) begin
                tick();
                if (rd_v === 1'b1) begin
                    check("readback word", rd_data,
                          rb_words[n % 4]);
                    n++;
                end
            end
            rb_req = 1'b0;
            repeat (2) tick();
            check("readback words", 16'(n), 16'h4);
            check("target", 16'(link.target_select), 16'(t));
        end
        results();
    end
endmodule : reply_gen_command_decode_test

// *** tb/rgcd_link_sva.sv ***
// Checker: timing relations on the command link between the two ends
`timescale 1ns/100ps
module rgcd_link_sva (
    input  wire logic        core_clk_in,
    input  wire logic        sys_rst_in,
    input  wire logic [7:0]  command,
    input  wire logic        command_strobe,
    input  wire logic        return_ram_load_command,
    input  wire logic        host_data_request,
    input  wire logic        host_return_valid,
    input  wire logic        ram_read_mode,
    input  wire logic [5:0]  status_bits
);
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (sys_rst_in);

    // ----------------------------------------------------------------
    // Helper counters
    // ----------------------------------------------------------------
    logic [2:0] req_cnt_ff;
    logic [3:0] since_stb_ff;

    // Only requests taken in read mode count toward the block
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in || !ram_read_mode) begin
            req_cnt_ff <= 3'h0;
        end else if (host_data_request && req_cnt_ff != 3'h7) begin
            req_cnt_ff <= req_cnt_ff + 3'h1;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            since_stb_ff <= 4'hf;
        end else if ($rose(command_strobe)) begin
            since_stb_ff <= 4'h0;
        end else if (since_stb_ff != 4'hf) begin
            since_stb_ff <= since_stb_ff + 4'h1;
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    a_status_cmd_bits: assert property (
        $rose(command_strobe) |-> ##7 status_bits == $past(command[7:2], 7))
        else $error("status word does not hold the command bits");
    a_status_quiet: assert property (
        !$stable(status_bits) |-> since_stb_ff <= 4'h8)
        else $error("status word changed without a command");
    a_load_write_mode: assert property (
        return_ram_load_command |-> !ram_read_mode)
        else $error("load command issued in read mode");
    a_load_to_read: assert property (
        return_ram_load_command |=> !ram_read_mode [*5] ##1 ram_read_mode)
        else $error("read mode not entered six cycles after load");
    a_four_reads: assert property (
        $fell(ram_read_mode) |-> req_cnt_ff == 3'h4)
        else $error("write mode resumed without four reads");
    a_req_in_read: assert property (
        host_data_request |-> ram_read_mode)
        else $error("data request while in write mode");
    a_valid_after_req: assert property (
        host_data_request && ram_read_mode && req_cnt_ff < 3'h4
        |=> host_return_valid)
        else $error("no return word after a data request");
    a_valid_cause: assert property (
        host_return_valid |-> $past(host_data_request))
        else $error("return word without a data request");
    a_reset_write: assert property (
        $past(sys_rst_in) |-> !ram_read_mode && !host_return_valid)
        else $error("return RAM not in write mode after reset");
endmodule : rgcd_link_sva

// *** verilog/rgcd_device.sv ***
// Module: command decode, pulse generators and return RAM
`timescale 1ns/100ps
module rgcd_device (
    input  wire logic                          core_clk_in,
    input  wire logic                          sys_rst_in,
    rgcd_if.device                             link,
    input  wire logic                          return_ram_count_enable_in,
    input  wire logic                          return_ram_output_enable_in,
    input  wire logic [rgcd_pkg::WORD_W-1:0]   gen_fields_in,
    input  wire logic [rgcd_pkg::WORD_W-1:0]   gen_train_in,
    input  wire logic                          gen_train_bit_in,
    input  wire logic                          gen_transmit_in,
    output logic [rgcd_pkg::NPULSE-1:0]        ctrl_pulse_out,
    output rgcd_pkg::rgcd_mode_t               mode_out,
    output logic                               if_diag_sel_out,
    output logic                               ps_select_out,
    output logic                               readback_source_select_out,
    output logic                               program_addr_ctrl_out,
    output logic                               micro_drive_enable_out,
    output logic [rgcd_pkg::WORD_W-1:0]        gen_read_data_out,
    output logic                               gen_read_valid_out
);
    import rgcd_pkg::*;

    // ----------------------------------------------------------------
    // Command capture and resync
    // ----------------------------------------------------------------
    // Strobe comes from the host domain: three-stage sampler
    logic [2:0]       strobe_sync_ff;
    logic             strobe_rise;
    logic [CMD_W-1:0] cmd_a_ff;
    logic [CMD_W-1:0] cmd_b_ff;

    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            strobe_sync_ff <= 3'h0;
        end else begin
            strobe_sync_ff <= {strobe_sync_ff[1:0], link.command_strobe};
        end
    end
    assign strobe_rise = strobe_sync_ff[1] & ~strobe_sync_ff[2];

    // Command held stable by host around the strobe edge
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            cmd_a_ff <= '0;
            cmd_b_ff <= '0;
        end else begin
            if (strobe_rise) begin
                cmd_a_ff <= link.command;
            end
            cmd_b_ff <= cmd_a_ff;
        end
    end

    // ----------------------------------------------------------------
    // Mode decode
    // ----------------------------------------------------------------
    rgcd_mode_t nxt_mode;
    rgcd_mode_t mode_ff;
    logic       diag_ff;

    always_comb begin
        case (cmd_b_ff[OP_LSB +: OP_W])
            OP_NORMAL: nxt_mode = RGCD_MODE_NORMAL;
            OP_RF:     nxt_mode = RGCD_MODE_RF;
            OP_TGT:    nxt_mode = RGCD_MODE_TGT;
            OP_MICRO:  nxt_mode = RGCD_MODE_MICRO;
            OP_BUF:    nxt_mode = RGCD_MODE_BUF;
            default:   nxt_mode = RGCD_MODE_ILLEGAL;
        endcase
    end

    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            mode_ff <= RGCD_MODE_NORMAL;
            diag_ff <= 1'b0;
        end else begin
            mode_ff <= nxt_mode;
            diag_ff <= (nxt_mode == RGCD_MODE_BUF);
        end
    end

    // ----------------------------------------------------------------
    // Self-resetting pulse generators
    // ----------------------------------------------------------------
    logic [NPULSE-1:0] latch_ff;
    logic [NPULSE-1:0] sync_ff;
    logic [NPULSE-1:0] dly_ff;
    logic [NPULSE-1:0] clr_ff;
    logic [NPULSE-1:0] pulse_ff;
    logic [NPULSE-1:0] allow;

    // Every mode but buffer: host may only reset or increment reply count
    // Gated by the command being pulsed, not the mode before it
    always_comb begin
        allow = {NPULSE{1'b1}};
        if (nxt_mode != RGCD_MODE_BUF) begin
            allow[BIT_DEC_RC] = 1'b0;
            allow[BIT_INC_RA] = 1'b0;
        end
    end

    genvar g;
    generate
        for (g = 0; g < NPULSE; g++) begin : gen_pulse
            // Latch clear is synchronous here: no async paths in design
            always_ff @(posedge core_clk_in) begin
                if (sys_rst_in) begin
                    latch_ff[g] <= 1'b0;
                end else if (strobe_rise && link.command[g]) begin
                    latch_ff[g] <= 1'b1;
                end else if (clr_ff[g]) begin
                    latch_ff[g] <= 1'b0;
                end
            end
            always_ff @(posedge core_clk_in) begin
                if (sys_rst_in) begin
                    sync_ff[g]  <= 1'b0;
                    dly_ff[g]   <= 1'b0;
                    clr_ff[g]   <= 1'b0;
                    pulse_ff[g] <= 1'b0;
                end else begin
                    sync_ff[g]  <= latch_ff[g] & ~clr_ff[g];
                    dly_ff[g]   <= sync_ff[g];
                    clr_ff[g]   <= sync_ff[g] & ~dly_ff[g];
                    // One cycle wide, one per command
                    pulse_ff[g] <= sync_ff[g] & ~dly_ff[g] & allow[g];
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // Status and control outputs
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            link.status_bits           <= '0;
            ps_select_out              <= 1'b0;
            readback_source_select_out <= 1'b0;
            program_addr_ctrl_out      <= 1'b0;
            micro_drive_enable_out     <= 1'b1;
        end else begin
            link.status_bits <= cmd_b_ff[CMD_W-1 -: STAT_W];
            ps_select_out    <= diag_ff & cmd_b_ff[BIT_PS_SEL];
            readback_source_select_out <= diag_ff & cmd_b_ff[BIT_RB_SEL];
            program_addr_ctrl_out  <= diag_ff;
            micro_drive_enable_out <= ~diag_ff;
        end
    end
    assign ctrl_pulse_out  = pulse_ff;
    assign mode_out        = mode_ff;
    assign if_diag_sel_out = diag_ff;

    // ----------------------------------------------------------------
    // Return RAM and its ping-pong sequencer
    // ----------------------------------------------------------------
    logic [WORD_W-1:0] ram_ff [RAM_DEPTH];
    logic [3:0]        addr_ff;
    logic [3:0]        load_cnt_ff;
    logic              read_mode_ff;
    logic              carry_ff;
    logic              window;
    logic              rd_step;
    logic              ram_active;

    // Return path only used in micro and target diagnostic modes
    assign ram_active = (mode_ff == RGCD_MODE_MICRO)
                      || (mode_ff == RGCD_MODE_TGT);
    assign window  = load_cnt_ff[3] & return_ram_count_enable_in;
    assign rd_step = read_mode_ff & link.host_data_request
                   & return_ram_count_enable_in & ~carry_ff;

    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in || !ram_active) begin
            load_cnt_ff <= LOAD_CLEAR;
        end else if (!read_mode_ff && !load_cnt_ff[3]
                     && link.return_ram_load_command
                     && return_ram_count_enable_in) begin
            load_cnt_ff <= LOAD_PRESET;
        end else if (window) begin
            load_cnt_ff <= load_cnt_ff + 4'h1; // wraps to 0
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in || !ram_active) begin
            addr_ff      <= RAM_FIRST;
            read_mode_ff <= 1'b0;
            carry_ff     <= 1'b0;
        end else if (carry_ff) begin
            addr_ff      <= RAM_FIRST;
            read_mode_ff <= ~read_mode_ff;
            carry_ff     <= 1'b0;
        end else if (window || rd_step) begin
            addr_ff  <= addr_ff + 4'h1;
            carry_ff <= (addr_ff == RAM_LAST);
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (window && !read_mode_ff) begin
            ram_ff[addr_ff] <= link.micro_wr_data;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            link.host_return_data  <= '0;
            link.host_return_valid <= 1'b0;
        end else begin
            link.host_return_valid <= rd_step & return_ram_output_enable_in;
            if (rd_step && return_ram_output_enable_in) begin
                link.host_return_data <= ram_ff[addr_ff];
            end
        end
    end
    assign link.ram_read_mode = read_mode_ff;

    // ----------------------------------------------------------------
    // Target generator readback
    // ----------------------------------------------------------------
    logic              rb_prev_ff;
    logic [3:0]        rb_shift_ff;
    logic [WORD_W-1:0] hold_ff;
    logic [WORD_W-1:0] train_ff;
    logic [WORD_W-1:0] word_sel;

    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            hold_ff  <= '0;
            train_ff <= '0;
        end else if (gen_transmit_in) begin
            hold_ff  <= gen_fields_in;
            train_ff <= {train_ff[WORD_W-2:0], gen_train_bit_in};
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            rb_prev_ff  <= 1'b0;
            rb_shift_ff <= 4'h0;
        end else begin
            rb_prev_ff  <= link.generator_readback_command;
            rb_shift_ff <= {rb_shift_ff[2:0],
                link.generator_readback_command & ~rb_prev_ff};
        end
    end

    always_comb begin
        case (rb_shift_ff)
            4'h1:    word_sel = hold_ff;
            4'h2:    word_sel = train_ff;
            4'h4:    word_sel = gen_fields_in;
            4'h8:    word_sel = gen_train_in;
            default: word_sel = '0;
        endcase
    end

    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            gen_read_data_out  <= '0;
            gen_read_valid_out <= 1'b0;
        end else begin
            gen_read_data_out  <= word_sel;
            gen_read_valid_out <= |rb_shift_ff;
        end
    end

endmodule : rgcd_device

// *** verilog/rgcd_host.sv ***
// Module: host/micro end issuing commands and moving return words
`timescale 1ns/100ps
module rgcd_host (
    input  wire logic                          core_clk_in,
    input  wire logic                          sys_rst_in,
    rgcd_if.host                               link,
    input  wire logic                          cmd_req_in,
    input  wire logic [rgcd_pkg::CMD_W-1:0]    cmd_in,
    input  wire logic                          block_req_in,
    input  wire logic [rgcd_pkg::WORD_W-1:0]   block_word_in,
    input  wire logic                          fetch_req_in,
    input  wire logic                          readback_req_in,
    input  wire logic [rgcd_pkg::TSEL_W-1:0]   target_select_in,
    output logic                               busy_out,
    output logic [rgcd_pkg::WORD_W-1:0]        fetched_word_out,
    output logic                               fetched_valid_out
);
    import rgcd_pkg::*;

    typedef enum {RGCD_IDLE, RGCD_STROBE, RGCD_LOAD, RGCD_FETCH} rgcd_st_t;
    rgcd_st_t   st_ff;
    logic [2:0] cnt_ff;

    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            st_ff                           <= RGCD_IDLE;
            cnt_ff                          <= 3'h0;
            link.command                    <= '0;
            link.command_strobe             <= 1'b0;
            link.return_ram_load_command    <= 1'b0;
            link.micro_wr_data              <= '0;
            link.host_data_request          <= 1'b0;
            link.generator_readback_command <= 1'b0;
            link.target_select              <= '0;
        end else begin
            link.return_ram_load_command    <= 1'b0;
            link.host_data_request          <= 1'b0;
            link.generator_readback_command <= readback_req_in;
            link.target_select <= target_select_in;
            case (st_ff)
                RGCD_IDLE: begin
                    cnt_ff <= 3'h0;
                    if (cmd_req_in) begin
                        link.command <= cmd_in;
                        st_ff        <= RGCD_STROBE;
                    end else if (block_req_in && !link.ram_read_mode) begin
                        link.return_ram_load_command <= 1'b1;
                        st_ff <= RGCD_LOAD;
                    end else if (fetch_req_in && link.ram_read_mode) begin
                        st_ff <= RGCD_FETCH;
                    end
                end
                RGCD_STROBE: begin
                    // Strobe held long for the device's sampler
                    link.command_strobe <= (cnt_ff < 3'h4);
                    cnt_ff <= cnt_ff + 3'h1;
                    if (cnt_ff == 3'h7) begin
                        st_ff <= RGCD_IDLE;
                    end
                end
                RGCD_LOAD: begin
                    link.micro_wr_data <= block_word_in;
                    cnt_ff <= cnt_ff + 3'h1;
                    if (cnt_ff == 3'(BLOCK_LEN)) begin
                        st_ff <= RGCD_IDLE;
                    end
                end
                RGCD_FETCH: begin
                    link.host_data_request <= 1'b1;
                    cnt_ff <= cnt_ff + 3'h1;
                    if (cnt_ff == 3'(BLOCK_LEN - 1)) begin
                        st_ff <= RGCD_IDLE;
                    end
                end
                default: st_ff <= RGCD_IDLE;
            endcase
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            busy_out          <= 1'b0;
            fetched_word_out  <= '0;
            fetched_valid_out <= 1'b0;
        end else begin
            busy_out          <= (st_ff != RGCD_IDLE);
            fetched_word_out  <= link.host_return_data;
            fetched_valid_out <= link.host_return_valid;
        end
    end

endmodule : rgcd_host

// *** verilog/rgcd_if.sv ***
// Interface: host/micro ports facing the reply generator command block
`timescale 1ns/100ps
interface rgcd_if;
    import rgcd_pkg::*;
    logic [CMD_W-1:0]  command;
    logic              command_strobe;
    logic              return_ram_load_command;
    logic [WORD_W-1:0] micro_wr_data;
    logic              host_data_request;
    logic              generator_readback_command;
    logic [TSEL_W-1:0] target_select;
    logic [WORD_W-1:0] host_return_data;
    logic              host_return_valid;
    logic              ram_read_mode;
    logic [STAT_W-1:0] status_bits;

    modport device (
        input  command, command_strobe, return_ram_load_command,
        input  micro_wr_data, host_data_request,
        input  generator_readback_command, target_select,
        output host_return_data, host_return_valid, ram_read_mode,
        output status_bits
    );
    modport host (
        output command, command_strobe, return_ram_load_command,
        output micro_wr_data, host_data_request,
        output generator_readback_command, target_select,
        input  host_return_data, host_return_valid, ram_read_mode,
        input  status_bits
    );
endinterface : rgcd_if

// *** verilog/rgcd_pkg.sv ***
// Package: constants and types shared by both ends of the command link
package rgcd_pkg;

    // ----------------------------------------------------------------
    // Command word layout
    // ----------------------------------------------------------------
    localparam int CMD_W       = 8;
    localparam int BIT_RESET   = 0;
    localparam int BIT_INC_RC  = 1;
    localparam int BIT_INC_RA  = 2;
    localparam int BIT_DEC_RC  = 3;
    localparam int BIT_PS_SEL  = 4;
    localparam int BIT_RB_SEL  = 5;
    localparam int OP_LSB      = 5;
    localparam int OP_W        = 3;
    localparam int STAT_W      = 6;
    localparam int NPULSE      = 4;

    localparam logic [2:0] OP_NORMAL = 3'h0;
    localparam logic [2:0] OP_RF     = 3'h1;
    localparam logic [2:0] OP_TGT    = 3'h2;
    localparam logic [2:0] OP_MICRO  = 3'h3;
    localparam logic [2:0] OP_BUF    = 3'h5;

    typedef enum logic [2:0] {
        RGCD_MODE_NORMAL,
        RGCD_MODE_RF,
        RGCD_MODE_TGT,
        RGCD_MODE_MICRO,
        RGCD_MODE_BUF,
        RGCD_MODE_ILLEGAL
    } rgcd_mode_t;

    // ----------------------------------------------------------------
    // Return RAM
    // ----------------------------------------------------------------
    localparam int         WORD_W      = 16;
    localparam int         RAM_DEPTH   = 16;
    localparam logic [3:0] RAM_FIRST   = 4'hb;
    localparam logic [3:0] RAM_LAST    = 4'he;
    localparam logic [3:0] LOAD_PRESET = 4'hc;
    localparam logic [3:0] LOAD_CLEAR  = 4'h0;
    localparam int         BLOCK_LEN   = 4;
    localparam int         TSEL_W      = 2;

endpackage : rgcd_pkg
